// *** hot_swap_status_fault_alarm_regs.sv ***
`timescale 1ns/10ps
// Operation
// - pin byte shows live power-good and analog pins
// - live bit 7 shows external fault asserted
// - live bit 6 shows shorted pass device
// - live bit 4 captures power-good input at expiry
// - live bit 3 shows bad pass device
// - live bit 2 shows current limiting engaged
// - live bit 1 set when both undervoltage inputs low
// - live bit 0 follows overvoltage input
// - latched byte resets zero; bit 7 external fault
// - latched bit 6 sticks on pass short
// - latched bit 5 on output low after good
// - latched bit 4 on power-good input fault
// - latched bit 3 on bad pass fault
// - latched bit 2 on overcurrent fault
// - latched bits 1, 0 on undervoltage, overvoltage
// - alarm bit 7 latches enable pin change
// - alarm bit 6 latches nonvolatile write
// - alarm bits 5, 4 sense high and low
// - alarm bits 3, 2 supply high and low
// - alarm bits 1, 0 power high and low
// - second alarm byte: analog input pairs
// - third alarm byte: analog pin pairs
module hot_swap_status_fault_alarm_regs
    import hot_swap_regs_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // register port from the management bus front end
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr_en,
    input  wire logic [7:0]   reg_wr_data,
    input  wire logic         reg_rd_en,
    output logic      [7:0]   reg_rd_data,
    output logic              reg_rd_valid,
    // pin levels, index 0 is pin 1
    input  wire logic [3:0]   power_good_io_pins,
    input  wire logic [3:0]   analog_io_pins,
    input  wire logic         enable_n,
    // pin roles
    input  wire logic         external_fault_select,
    input  wire logic         external_fault_active_high,
    input  wire logic         power_good_input_active_high,
    input  wire logic         power_good_check_expired,
    input  wire logic         power_good_latched,
    // detector levels and qualified events
    input  wire fault_level_s fault_level,
    input  wire fault_event_s fault_event,
    input  wire logic         nv_write_done,
    input  wire meas_s        measurement,
    // live fault byte for other logic
    output logic      [7:0]   live_fault_condition
);

    logic [7:0]  pin_level_snapshot;
    logic [7:0]  latched_fault_events;
    logic [7:0]  alarm_log_power_sense;
    logic [7:0]  alarm_log_analog_inputs;
    logic [7:0]  alarm_log_analog_io;
    logic [7:0]  fault_set;
    logic [7:0]  alarm_ps_set;
    logic [7:0]  alarm_ain_set;
    logic [7:0]  alarm_aio_set;
    logic        power_good_input_live_r;
    logic        external_fault_prev_r;
    logic        enable_n_prev_r;
    logic        enable_primed_r;
    logic        external_fault_live;
    logic        external_fault_rise;
    logic        enable_changed;
    logic        output_lost_after_good;
    logic        latched_clear;
    logic [1:0]  meas_pair;
    logic [7:0]  reg_rd_data_r;
    logic [7:0]  reg_rd_data_nxt;
    logic        reg_rd_valid_r;

    // {above max, below min}; unsigned compare of the raw result
    function automatic logic [1:0] alarm_pair(input meas_s m);
        alarm_pair = {m.value > m.max_th, m.value < m.min_th};
    endfunction : alarm_pair

    // place a pair: slot 0 in bits 7:6 down to slot 3 in bits 1:0
    function automatic logic [7:0] place_pair(input logic [1:0] slot, input logic [1:0] pair);
        place_pair = {pair, 6'h00} >> {slot, 1'b0};
    endfunction : place_pair

    // bit 7 power-good pins 1..4, bit 3 analog pins 1..4
    assign pin_level_snapshot = {power_good_io_pins[0], power_good_io_pins[1],
                                 power_good_io_pins[2], power_good_io_pins[3],
                                 analog_io_pins[0], analog_io_pins[1],
                                 analog_io_pins[2], analog_io_pins[3]};

    // external fault at pin 4, polarity per the pin setting
    assign external_fault_live = external_fault_select &&
        (external_fault_active_high ? power_good_io_pins[3]
                                    : !power_good_io_pins[3]);

    // live fault byte, all levels except the captured input bit
    always_comb begin
        live_fault_condition = 8'h00;
        live_fault_condition[BIT_EXTERNAL_FAULT] = external_fault_live;
        live_fault_condition[BIT_PASS_SHORT] = fault_level.pass_device_short;
        live_fault_condition[BIT_OUTPUT_LOW] = fault_level.output_below_threshold;
        live_fault_condition[BIT_POWER_GOOD_IN] = power_good_input_live_r;
        live_fault_condition[BIT_PASS_BAD] = fault_level.pass_device_bad;
        live_fault_condition[BIT_CURRENT_LIMIT] = fault_level.current_limit;
        live_fault_condition[BIT_UNDERVOLTAGE] =
            !fault_level.undervoltage_high_comparator &&
            !fault_level.undervoltage_low_comparator;
        live_fault_condition[BIT_OVERVOLTAGE] = fault_level.overvoltage_comparator;
    end

    // pin 3 sampled only when the check timer runs out, then held
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            power_good_input_live_r <= 1'b0;
        end else if (power_good_check_expired) begin
            power_good_input_live_r <= power_good_input_active_high ?
                                       !power_good_io_pins[2] : power_good_io_pins[2];
        end
    end

    // edge history for the external fault and enable pin
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            external_fault_prev_r <= 1'b0;
            enable_n_prev_r       <= 1'b1;
            enable_primed_r       <= 1'b0;
        end else begin
            external_fault_prev_r <= external_fault_live;
            enable_n_prev_r       <= enable_n;
            enable_primed_r       <= 1'b1;
        end
    end

    // priming avoids a false change report on the first cycle after reset
    assign enable_changed      = enable_primed_r && (enable_n != enable_n_prev_r);
    assign external_fault_rise = external_fault_live && !external_fault_prev_r;
    assign output_lost_after_good = power_good_latched &&
                                    fault_level.output_below_threshold;
    assign latched_clear = reg_wr_en && (reg_addr == ADDR_LATCHED_FAULT_EVENTS);

    // latched fault set terms
    always_comb begin
        fault_set = 8'h00;
        fault_set[BIT_EXTERNAL_FAULT] = external_fault_rise;
        fault_set[BIT_PASS_SHORT]     = fault_level.pass_device_short;
        fault_set[BIT_OUTPUT_LOW]     = output_lost_after_good;
        fault_set[BIT_POWER_GOOD_IN]  = fault_event.power_good_input_fault;
        fault_set[BIT_PASS_BAD]       = fault_event.pass_bad_fault;
        fault_set[BIT_CURRENT_LIMIT]  = fault_event.overcurrent_fault;
        fault_set[BIT_UNDERVOLTAGE]   = fault_event.undervoltage_fault;
        fault_set[BIT_OVERVOLTAGE]    = fault_event.overvoltage_fault;
    end

    assign meas_pair = measurement.valid ? alarm_pair(measurement) : 2'b00;

    // route each finished measurement to its alarm pair
    always_comb begin
        alarm_ps_set  = 8'h00;
        alarm_ain_set = 8'h00;
        alarm_aio_set = 8'h00;
        alarm_ps_set[BIT_ENABLE_CHANGED] = enable_changed;
        alarm_ps_set[BIT_NV_WRITTEN]     = nv_write_done;
        case (measurement.kind)
            MEAS_SENSE: begin
                alarm_ps_set[BIT_SENSE_HIGH] = meas_pair[1];
                alarm_ps_set[BIT_SENSE_LOW]  = meas_pair[0];
            end
            MEAS_SUPPLY: begin
                alarm_ps_set[BIT_SUPPLY_HIGH] = meas_pair[1];
                alarm_ps_set[BIT_SUPPLY_LOW]  = meas_pair[0];
            end
            MEAS_POWER: begin
                alarm_ps_set[BIT_POWER_HIGH] = meas_pair[1];
                alarm_ps_set[BIT_POWER_LOW]  = meas_pair[0];
            end
            MEAS_AIN1, MEAS_AIN2, MEAS_AIN3, MEAS_AIN4: begin
                alarm_ain_set = place_pair(2'(measurement.kind - MEAS_AIN1), meas_pair);
            end
            MEAS_AIO1, MEAS_AIO2, MEAS_AIO3, MEAS_AIO4: begin
                alarm_aio_set = place_pair(2'(measurement.kind - MEAS_AIO1), meas_pair);
            end
            default: begin
                alarm_ps_set[BIT_SENSE_HIGH] = 1'b0;
            end
        endcase
    end

    // sticky bytes, cleared by writing zeros
    sticky_flag_byte #(.W(8), .RESET_VALUE(LATCHED_FAULT_RESET)) u_latched_fault (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_evt  (fault_set),
        .clr_wr   (latched_clear),
        .clr_data (reg_wr_data),
        .flags    (latched_fault_events)
    );

    sticky_flag_byte #(.W(8), .RESET_VALUE(ALARM_LOG_RESET)) u_alarm_power_sense (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_evt  (alarm_ps_set),
        .clr_wr   (reg_wr_en && reg_addr == ADDR_ALARM_LOG_POWER_SENSE),
        .clr_data (reg_wr_data),
        .flags    (alarm_log_power_sense)
    );

    sticky_flag_byte #(.W(8), .RESET_VALUE(ALARM_LOG_RESET)) u_alarm_analog_inputs (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_evt  (alarm_ain_set),
        .clr_wr   (reg_wr_en && reg_addr == ADDR_ALARM_LOG_ANALOG_INPUTS),
        .clr_data (reg_wr_data),
        .flags    (alarm_log_analog_inputs)
    );

    sticky_flag_byte #(.W(8), .RESET_VALUE(ALARM_LOG_RESET)) u_alarm_analog_io (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_evt  (alarm_aio_set),
        .clr_wr   (reg_wr_en && reg_addr == ADDR_ALARM_LOG_ANALOG_IO),
        .clr_data (reg_wr_data),
        .flags    (alarm_log_analog_io)
    );

    // read decode; writes to read-only bytes are ignored
    always_comb begin
        if (reg_addr == ADDR_PIN_LEVEL_SNAPSHOT) begin
            reg_rd_data_nxt = pin_level_snapshot;
        end else if (reg_addr == ADDR_LIVE_FAULT_CONDITION) begin
            reg_rd_data_nxt = live_fault_condition;
        end else if (reg_addr == ADDR_LATCHED_FAULT_EVENTS) begin
            reg_rd_data_nxt = latched_fault_events;
        end else if (reg_addr == ADDR_ALARM_LOG_POWER_SENSE) begin
            reg_rd_data_nxt = alarm_log_power_sense;
        end else if (reg_addr == ADDR_ALARM_LOG_ANALOG_INPUTS) begin
            reg_rd_data_nxt = alarm_log_analog_inputs;
        end else if (reg_addr == ADDR_ALARM_LOG_ANALOG_IO) begin
            reg_rd_data_nxt = alarm_log_analog_io;
        end else begin
            reg_rd_data_nxt = UNMAPPED_READ_VALUE;
        end
    end

    // read data held until the next read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_data_r  <= 8'h00;
            reg_rd_valid_r <= 1'b0;
        end else begin
            reg_rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data_r <= reg_rd_data_nxt;
            end
        end
    end

    assign reg_rd_data  = reg_rd_data_r;
    assign reg_rd_valid = reg_rd_valid_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_read(logic [7:0] a);
        reg_rd_en && reg_addr == a;
    endsequence

    sequence s_no_clear(logic [7:0] a);
        !(reg_wr_en && reg_addr == a);
    endsequence

    property p_pin_read;
        s_read(ADDR_PIN_LEVEL_SNAPSHOT) |=>
            reg_rd_valid && reg_rd_data[7:4] ==
            {$past(power_good_io_pins[0]), $past(power_good_io_pins[1]),
             $past(power_good_io_pins[2]), $past(power_good_io_pins[3])};
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin byte read wrong");

    property p_ext_live;
        external_fault_select && !external_fault_active_high && !power_good_io_pins[3]
            |-> live_fault_condition[BIT_EXTERNAL_FAULT];
    endproperty
    a_ext_live: assert property (p_ext_live) else $error("external fault not shown");

    property p_short_live;
        live_fault_condition[BIT_PASS_SHORT] == fault_level.pass_device_short;
    endproperty
    a_short_live: assert property (p_short_live) else $error("short status wrong");

    property p_pgi_capture;
        power_good_check_expired && !power_good_input_active_high |=>
            live_fault_condition[BIT_POWER_GOOD_IN] == $past(power_good_io_pins[2]);
    endproperty
    a_pgi_capture: assert property (p_pgi_capture) else $error("capture wrong");

    property p_uv_live;
        fault_level.undervoltage_high_comparator |-> !live_fault_condition[BIT_UNDERVOLTAGE];
    endproperty
    a_uv_live: assert property (p_uv_live) else $error("undervoltage shown");

    property p_short_latch;
        fault_level.pass_device_short ##1 !fault_level.pass_device_short [*2]
            |-> latched_fault_events[BIT_PASS_SHORT] ||
                $past(latched_clear);
    endproperty
    a_short_latch: assert property (p_short_latch) else $error("short not held");

    property p_lost_latch;
        power_good_latched && fault_level.output_below_threshold
            |=> latched_fault_events[BIT_OUTPUT_LOW];
    endproperty
    a_lost_latch: assert property (p_lost_latch) else $error("output loss lost");

    property p_enable_change;
        enable_primed_r && $changed(enable_n) |=> alarm_log_power_sense[BIT_ENABLE_CHANGED];
    endproperty
    a_enable_change: assert property (p_enable_change) else $error("enable change lost");

    property p_sense_high;
        measurement.valid && measurement.kind == MEAS_SENSE &&
        measurement.value > measurement.max_th |=> alarm_log_power_sense[BIT_SENSE_HIGH];
    endproperty
    a_sense_high: assert property (p_sense_high) else $error("sense alarm lost");

    property p_ain1_low;
        measurement.valid && measurement.kind == MEAS_AIN1 &&
        measurement.value < measurement.min_th |=> alarm_log_analog_inputs[6];
    endproperty
    a_ain1_low: assert property (p_ain1_low) else $error("input 1 alarm lost");

    property p_hold;
        latched_fault_events[BIT_OVERVOLTAGE] ##0 s_no_clear(ADDR_LATCHED_FAULT_EVENTS)
            |=> latched_fault_events[BIT_OVERVOLTAGE];
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear");

endmodule : hot_swap_status_fault_alarm_regs

// *** hot_swap_regs_pkg.sv ***
package hot_swap_regs_pkg;

    // register offsets on the management bus
    localparam logic [7:0] ADDR_PIN_LEVEL_SNAPSHOT     = 8'h02;
    localparam logic [7:0] ADDR_LIVE_FAULT_CONDITION   = 8'h03;
    localparam logic [7:0] ADDR_LATCHED_FAULT_EVENTS   = 8'h04;
    localparam logic [7:0] ADDR_ALARM_LOG_POWER_SENSE  = 8'h05;
    localparam logic [7:0] ADDR_ALARM_LOG_ANALOG_INPUTS = 8'h06;
    localparam logic [7:0] ADDR_ALARM_LOG_ANALOG_IO    = 8'h07;

    // values after reset and answer to an unmapped read
    localparam logic [7:0] LATCHED_FAULT_RESET = 8'h00;
    localparam logic [7:0] ALARM_LOG_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // fault bit positions, shared by live and latched bytes
    localparam int BIT_EXTERNAL_FAULT = 7;
    localparam int BIT_PASS_SHORT     = 6;
    localparam int BIT_OUTPUT_LOW     = 5;
    localparam int BIT_POWER_GOOD_IN  = 4;
    localparam int BIT_PASS_BAD       = 3;
    localparam int BIT_CURRENT_LIMIT  = 2;
    localparam int BIT_UNDERVOLTAGE   = 1;
    localparam int BIT_OVERVOLTAGE    = 0;

    // power/sense alarm byte positions
    localparam int BIT_ENABLE_CHANGED = 7;
    localparam int BIT_NV_WRITTEN     = 6;
    localparam int BIT_SENSE_HIGH     = 5;
    localparam int BIT_SENSE_LOW      = 4;
    localparam int BIT_SUPPLY_HIGH    = 3;
    localparam int BIT_SUPPLY_LOW     = 2;
    localparam int BIT_POWER_HIGH     = 1;
    localparam int BIT_POWER_LOW      = 0;

    localparam int MEAS_W = 16;

    typedef enum logic [3:0] {
        MEAS_SENSE, MEAS_SUPPLY, MEAS_POWER,
        MEAS_AIN1, MEAS_AIN2, MEAS_AIN3, MEAS_AIN4,
        MEAS_AIO1, MEAS_AIO2, MEAS_AIO3, MEAS_AIO4
    } meas_kind_e;

    // one finished converter result with its thresholds
    typedef struct packed {
        logic              valid;
        meas_kind_e        kind;
        logic [MEAS_W-1:0] value;
        logic [MEAS_W-1:0] min_th;
        logic [MEAS_W-1:0] max_th;
    } meas_s;

    // live analog detector levels
    typedef struct packed {
        logic pass_device_short;
        logic output_below_threshold;
        logic pass_device_bad;
        logic current_limit;
        logic undervoltage_high_comparator;
        logic undervoltage_low_comparator;
        logic overvoltage_comparator;
    } fault_level_s;

    // qualified fault events, one-cycle pulses
    typedef struct packed {
        logic power_good_input_fault;
        logic pass_bad_fault;
        logic overcurrent_fault;
        logic undervoltage_fault;
        logic overvoltage_fault;
    } fault_event_s;

endpackage : hot_swap_regs_pkg

// *** sticky_flag_byte.sv ***
`timescale 1ns/10ps
module sticky_flag_byte
    import hot_swap_regs_pkg::*;
#(
    parameter int         W          = 8,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] set_evt,
    input  wire logic         clr_wr,
    input  wire logic [W-1:0] clr_data,
    output logic      [W-1:0] flags
);

    logic [W-1:0] flags_r;
    logic [W-1:0] clear_mask;

    // a zero written to a bit clears it; ones leave it alone
    assign clear_mask = clr_wr ? ~clr_data : '0;

    // set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= RESET_VALUE[W-1:0];
        end else begin
            flags_r <= (flags_r & ~clear_mask) | set_evt;
        end
    end

    assign flags = flags_r;

endmodule : sticky_flag_byte

// *** host_model.sv ***
`timescale 1ns/10ps
module host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en
);
    // idle bus: strobes low, address parked off the map
    initial begin
        reg_addr    = 8'hFF;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // one-cycle read; answer taken mid-cycle while valid stands
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge core_clk);
        reg_addr  = addr;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~addr; // released lines do not keep the old value
        data      = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hXX;
    endtask : rd

    // one-cycle write; a zero bit clears, a one leaves the flag
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        reg_addr    = addr;
        reg_wr_data = data;
        reg_wr_en   = 1'b1;
        @(negedge core_clk);
        reg_wr_en   = 1'b0;
        reg_addr    = ~addr;
        reg_wr_data = ~data;
    endtask : wr
endmodule : host_model

// *** hot_swap_status_fault_alarm_regs_tb.sv ***
`timescale 1ns/10ps
module hot_swap_status_fault_alarm_regs_tb;
    import hot_swap_regs_pkg::*;
    logic         core_clk, nrst, reg_wr_en, reg_rd_en, reg_rd_valid, enable_n;
    logic [7:0]   reg_addr, reg_wr_data, reg_rd_data, live;
    logic [3:0]   pg_pins, aio_pins;
    logic         ext_sel, ext_high, pgi_high, pg_expired, pg_latched, nv_done;
    fault_level_s lvl;
    fault_event_s evt;
    meas_s        meas;
    int           err_count, compares, cycles;

    hot_swap_status_fault_alarm_regs hot_swap_status_fault_alarm_regs_inst (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .power_good_io_pins(pg_pins),
        .analog_io_pins(aio_pins), .enable_n(enable_n), .external_fault_select(ext_sel),
        .external_fault_active_high(ext_high), .power_good_input_active_high(pgi_high),
        .power_good_check_expired(pg_expired), .power_good_latched(pg_latched),
        .fault_level(lvl), .fault_event(evt), .nv_write_done(nv_done),
        .measurement(meas), .live_fault_condition(live));
    host_model host_model_inst (
        .core_clk(core_clk), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_model_inst.rd(a, v);
        chk(what, exp, v);
    endtask : rdc

    task automatic t_reset_map;
        rdc("latched reset", ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        rdc("alarm1 reset", ADDR_ALARM_LOG_POWER_SENSE, 8'h00);
        rdc("alarm2 reset", ADDR_ALARM_LOG_ANALOG_INPUTS, 8'h00);
        rdc("alarm3 reset", ADDR_ALARM_LOG_ANALOG_IO, 8'h00);
        rdc("unmapped", 8'h20, 8'h00);
    endtask : t_reset_map

    // pin 1 lands in the top bit of each nibble
    task automatic t_pins;
        logic [7:0] pat [4] = '{8'h81, 8'h5A, 8'h3C, 8'hF0};
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            {pg_pins, aio_pins} = pat[i];
            for (int k = 0; k < 4; k++) begin
                e[7-k] = pg_pins[k];
                e[3-k] = aio_pins[k];
            end
            host_model_inst.wr(ADDR_PIN_LEVEL_SNAPSHOT, ~e);
            rdc("pin snapshot", ADDR_PIN_LEVEL_SNAPSHOT, e);
        end
        {pg_pins, aio_pins} = 8'h00;
    endtask : t_pins

    // walk one detector at a time; none high means undervoltage
    task automatic t_live;
        logic [6:0] l;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            l   = (i == 7) ? 7'h00 : 7'h40 >> i;
            lvl = fault_level_s'(l);
            e   = {1'b0, l[6], l[5], 1'b0, l[4], l[3], ~l[2] & ~l[1], l[0]};
            #1 chk("live byte", e, live);
        end
        rdc("live read", ADDR_LIVE_FAULT_CONDITION, 8'h02);
        rdc("short latched", ADDR_LATCHED_FAULT_EVENTS, 8'h40);
        host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        rdc("short cleared", ADDR_LATCHED_FAULT_EVENTS, 8'h00);
    endtask : t_live

    task automatic pulse_expiry(input logic [7:0] e);
        @(negedge core_clk);
        pg_expired = 1'b1;
        @(negedge core_clk);
        pg_expired = 1'b0;
        chk("captured pgi", e, live & 8'h10);
    endtask : pulse_expiry

    task automatic t_ext_pgi;
        @(negedge core_clk);
        {ext_sel, ext_high} = 2'b11;
        #1 chk("ext idle", 8'h00, live & 8'h80);
        @(negedge core_clk);
        pg_pins[3] = 1'b1;
        #1 chk("ext high", 8'h80, live & 8'h80);
        rdc("ext latched", ADDR_LATCHED_FAULT_EVENTS, 8'h80);
        ext_high = 1'b0;
        #1 chk("ext low idle", 8'h00, live & 8'h80);
        host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        pg_pins[3] = 1'b0;
        #1 chk("ext low asserted", 8'h80, live & 8'h80);
        rdc("ext low latched", ADDR_LATCHED_FAULT_EVENTS, 8'h80);
        {ext_sel, pg_pins[3]} = 2'h0;
        host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        {pgi_high, pg_pins[2]} = 2'b01;
        pulse_expiry(8'h10);
        pgi_high = 1'b1;
        pulse_expiry(8'h00);
        pg_pins[2] = 1'b0;
        pulse_expiry(8'h10);
    endtask : t_ext_pgi

    // event bit j lands in latched bit j
    task automatic t_latched;
        for (int j = 0; j < 5; j++) begin
            @(negedge core_clk);
            evt = fault_event_s'(5'h01 << j);
            @(negedge core_clk);
            evt = '0;
            host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'hFF);
            rdc("event latched", ADDR_LATCHED_FAULT_EVENTS, 8'h01 << j);
            host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        end
        lvl.output_below_threshold = 1'b1;
        rdc("low before good", ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        pg_latched = 1'b1;
        rdc("low after good", ADDR_LATCHED_FAULT_EVENTS, 8'h20);
        {lvl.output_below_threshold, evt} = 6'h01;
        host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
        evt = '0;
        rdc("set beats clear", ADDR_LATCHED_FAULT_EVENTS, 8'h01);
        host_model_inst.wr(ADDR_LATCHED_FAULT_EVENTS, 8'h00);
    endtask : t_latched

    // high then low alarm per kind; equal values must not alarm
    task automatic t_alarms;
        int         hb;
        logic [7:0] a;
        meas = '{1'b0, MEAS_SENSE, 16'hFFFF, 16'h0020, 16'h0080};
        @(negedge core_clk);
        meas = '{1'b1, MEAS_POWER, 16'h0050, 16'h0050, 16'h0050};
        @(negedge core_clk);
        meas.valid = 1'b0;
        rdc("no alarm", ADDR_ALARM_LOG_POWER_SENSE, 8'h00);
        for (int k = 0; k < 11; k++) begin
            for (int h = 0; h < 2; h++) begin
                a  = (k < 3) ? 8'h05 : (k < 7) ? 8'h06 : 8'h07;
                hb = (k < 3) ? 5 - 2 * k : (k < 7) ? 13 - 2 * k : 21 - 2 * k;
                meas = '{1'b1, meas_kind_e'(k), h ? 16'h0010 : 16'h0100,
                         16'h0020, 16'h0080};
                @(negedge core_clk);
                meas.valid = 1'b0;
                rdc("alarm", a, 8'h01 << (hb - h));
                host_model_inst.wr(a, 8'h00);
            end
        end
        enable_n = 1'b0;
        rdc("enable changed", ADDR_ALARM_LOG_POWER_SENSE, 8'h80);
        nv_done = 1'b1;
        @(negedge core_clk);
        nv_done = 1'b0;
        rdc("nv written", ADDR_ALARM_LOG_POWER_SENSE, 8'hC0);
    endtask : t_alarms

    initial begin
        {nrst, enable_n, ext_sel, ext_high, pgi_high, pg_expired} = 6'h10;
        {pg_latched, nv_done, pg_pins, aio_pins} = 10'h000;
        {lvl, evt} = '0;
        meas = '0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        t_reset_map();
        t_pins();
        t_live();
        t_ext_pgi();
        t_latched();
        t_alarms();
        give_verdict();
    end
endmodule : hot_swap_status_fault_alarm_regs_tb
